// ===== src/disk_seq_regs.vh
// register indices, field positions, reset values and timing counts for the sequencer
`ifndef DISK_SEQ_REGS_VH
`define DISK_SEQ_REGS_VH
// register indices; byte address is four times the index
`define IDX_CMD 6'h10
`define IDX_OPCTL 6'h11
`define IDX_STATUS 6'h12
`define IDX_OPCOUNT 6'h13
`define IDX_SECTCNT 6'h14
`define IDX_PATTERN 6'h15
`define IDX_HDRCTL 6'h16
`define IDX_HBC 6'h17
`define IDX_ERROR 6'h18
// command register fields
`define CMD_DO_HI 7
`define CMD_DO_LO 6
`define CMD_HO_HI 5
`define CMD_HO_LO 4
`define CMD_MULTI 2
`define CMD_START_SEL 1
`define OP_NONE 2'h0
`define DO_WRITE 2'h2
`define DO_READ 2'h3
`define HO_COMPARE 2'h1
// operation control fields
`define OC_RESET 0
`define OC_REENABLE 1
`define OC_INTERLOCK 2
`define OC_HDR_IE 3
`define OC_ERR_IE 4
// error register fields
`define ERR_DATA_FIELD 0
`define ERR_NO_SYNC 1
`define ERR_NOT_FOUND 2
`define ERR_OVERRUN 3
`define ERR_FIFO_LOST 4
`define ERR_LATE_IL 5
`define ERR_HDR_FAIL 6
`define ERR_CORR_FAIL 7
// status fields and header control field
`define ST_BUSY 0
`define ST_NEXT_CMD 1
`define ST_ERROR 2
`define ST_DISABLED 3
`define HDRCTL_SUBST 0
// reset values and field figures
`define OPCOUNT_RST 8'h01
`define DATA_BYTES 10'h200
`define PREAMBLE_BYTES 10'h00c
`define PREAMBLE_BYTE 8'h00
`define SYNC_BYTE 8'ha1
`define CRC_POLY 8'h07
`define INDEX_LIMIT 2'h2
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ===== src/check_accum.v
// running check byte over a field, cleared at field start
module check_accum
(
    input wire aclk,
    input wire aresetn,
    input wire clear,
    input wire step,
    input wire [7:0] din,
    output reg [7:0] crc
);
`include "disk_seq_regs.vh"

    function [7:0] crc8;
        input [7:0] c;
        input [7:0] d;
        integer i;
        reg [7:0] r;
        begin
            r = c ^ d;
            for (i = 0; i < 8; i = i + 1)
                r = r[7] ? ({r[6:0], 1'b0} ^ `CRC_POLY) : {r[6:0], 1'b0};
            crc8 = r;
        end
    endfunction

    always @(posedge aclk)
    begin
        if (!aresetn || clear)
            crc <= 8'h00;
        else if (step)
            crc <= crc8(crc, din);
    end
endmodule // check_accum

// ===== src/field_counter.v
// byte down counter for one disk field
module field_counter
(
    input wire aclk,
    input wire aresetn,
    input wire load,
    input wire [9:0] load_val,
    input wire dec,
    output reg [9:0] count
);
    always @(posedge aclk)
    begin
        if (!aresetn)
            count <= 10'h000;
        else if (load)
            count <= load_val;
        else if (dec && count != 10'h000)
            count <= count - 10'h001;
    end
endmodule // field_counter

// ===== src/disk_command_sequencer.v
// disk command sequencer with an axi4-lite register slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`include "disk_seq_regs.vh"

// Contract
// - read: sync align, bytes to fifo, then check
// - write: preamble, sync, data, appended check byte
// - start select set: next sector or immediately
// - start select clear: wait for index pulse
// - both start conditions work for every command
// - multi-sector bit picks repeat or single sector
// - single sector: header, data, then end
// - multi-sector repeats operation count times, max 255
// - substitute sector counter for header pattern byte
// - per sector: counter up, count down, until zero
// - good header raises next-command ready, interrupt
// - missed counter write before next header: abort
// - two index pulses without header: not found
// - error stops command, flags, interrupts, holds state
// - distinct flag for each of eight error causes
// - reset bit set then clear, then re-enable
// - compare header: all match and good check
module disk_command_sequencer
(
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire hard_sectored,
    input wire index_pulse,
    input wire sector_pulse,
    input wire id_found,
    input wire [7:0] id_byte,
    input wire id_check_ok,
    input wire data_sync_found,
    input wire data_sync_missing,
    input wire disk_byte_valid,
    input wire [7:0] disk_byte,
    input wire disk_byte_tick,
    input wire sector_overrun,
    input wire correction_failed,
    output reg fifo_in_valid,
    output reg [7:0] fifo_in_data,
    input wire fifo_in_ready,
    input wire fifo_out_valid,
    input wire [7:0] fifo_out_data,
    output reg fifo_out_take,
    output reg disk_wr_gate,
    output reg disk_wr_strobe,
    output reg [7:0] disk_wr_byte,
    output reg irq
);

    // ************************************************
    // states
    // ************************************************
    localparam S_IDLE = 4'h0;
    localparam S_WAIT_START = 4'h1;
    localparam S_SEARCH = 4'h2;
    localparam S_DSYNC = 4'h3;
    localparam S_RDATA = 4'h4;
    localparam S_RCHK = 4'h5;
    localparam S_WPRE = 4'h6;
    localparam S_WDATA = 4'h7;
    localparam S_WCHK = 4'h8;
    localparam S_SECT_END = 4'h9;
    localparam S_ERR = 4'ha;

    reg [3:0] state;
    reg [7:0] cmd;
    reg [4:0] opctl;
    reg disabled;
    reg [7:0] opcount;
    reg [7:0] sect_cnt;
    reg [7:0] pattern;
    reg subst;
    reg [7:0] hbc;
    reg [7:0] err;
    reg next_cmd_ready;
    reg hbc_written;
    reg il_armed;
    reg cmd_pending;
    reg [1:0] index_seen;
    reg cnt_load;
    reg [9:0] cnt_val;
    reg cnt_dec;
    reg crc_clear;
    reg crc_step;
    reg [7:0] crc_din;
    reg [31:0] rd_mux;
    reg rd_hit;
    wire [9:0] count;
    wire [7:0] crc;
    wire [1:0] dop = cmd[`CMD_DO_HI:`CMD_DO_LO];
    wire [1:0] hop = cmd[`CMD_HO_HI:`CMD_HO_LO];
    wire wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    wire rd_fire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    wire we = wr_fire && s_axi_wstrb[0];
    wire [5:0] widx = s_axi_awaddr[7:2];
    wire [7:0] wd = s_axi_wdata[7:0];
    wire active = state != S_IDLE && state != S_ERR;
    wire [7:0] hdr_ref = subst ? sect_cnt : pattern;
    wire byte_match = (hop != `HO_COMPARE) || (id_byte == hdr_ref);
    wire last_byte = count == 10'h001;

    field_counter u_field_counter
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(cnt_load),
        .load_val(cnt_val),
        .dec(cnt_dec),
        .count(count)
    );

    check_accum u_check_accum
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(crc_clear),
        .step(crc_step),
        .din(crc_din),
        .crc(crc)
    );

    // ************************************************
    // field counter and check byte steering
    // ************************************************
    always @*
    begin
        cnt_load = 1'b0;
        cnt_val = `DATA_BYTES;
        cnt_dec = 1'b0;
        crc_clear = 1'b0;
        crc_step = 1'b0;
        crc_din = disk_byte;
        case (state)
            S_SEARCH:
            begin
                cnt_load = 1'b1;
                cnt_val = `PREAMBLE_BYTES;
            end
            S_DSYNC:
            begin
                cnt_load = data_sync_found;
                crc_clear = 1'b1;
            end
            S_RDATA:
            begin
                cnt_dec = disk_byte_valid;
                crc_step = disk_byte_valid;
            end
            S_WPRE:
            begin
                cnt_dec = disk_byte_tick;
                cnt_load = disk_byte_tick && count == 10'h000;
                crc_clear = 1'b1;
            end
            S_WDATA:
            begin
                cnt_dec = disk_byte_tick && fifo_out_valid;
                crc_step = disk_byte_tick && fifo_out_valid;
                crc_din = fifo_out_data;
            end
            default:
            begin
                cnt_load = 1'b0;
            end
        endcase
    end

    // ************************************************
    // register read decode
    // ************************************************
    always @*
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (s_axi_araddr[7:2])
            `IDX_CMD: rd_mux[7:0] = cmd;
            `IDX_OPCTL: rd_mux[4:0] = opctl;
            `IDX_STATUS:
            begin
                rd_mux[`ST_BUSY] = active;
                rd_mux[`ST_NEXT_CMD] = next_cmd_ready;
                rd_mux[`ST_ERROR] = state == S_ERR;
                rd_mux[`ST_DISABLED] = disabled;
            end
            `IDX_OPCOUNT: rd_mux[7:0] = opcount;
            `IDX_SECTCNT: rd_mux[7:0] = sect_cnt;
            `IDX_PATTERN: rd_mux[7:0] = pattern;
            `IDX_HDRCTL: rd_mux[`HDRCTL_SUBST] = subst;
            `IDX_HBC: rd_mux[7:0] = hbc;
            `IDX_ERROR: rd_mux[7:0] = err;
            default: rd_hit = 1'b0;
        endcase
    end

    // ************************************************
    // bus slave, registers and sequencer
    // ************************************************
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            state <= S_IDLE;
            cmd <= 8'h00;
            opctl <= 5'h00;
            disabled <= 1'b0;
            opcount <= `OPCOUNT_RST;
            sect_cnt <= 8'h00;
            pattern <= 8'h00;
            subst <= 1'b0;
            hbc <= 8'h00;
            err <= 8'h00;
            next_cmd_ready <= 1'b0;
            hbc_written <= 1'b0;
            il_armed <= 1'b0;
            cmd_pending <= 1'b0;
            index_seen <= 2'h0;
            fifo_in_valid <= 1'b0;
            fifo_in_data <= 8'h00;
            fifo_out_take <= 1'b0;
            disk_wr_gate <= 1'b0;
            disk_wr_strobe <= 1'b0;
            disk_wr_byte <= 8'h00;
            irq <= 1'b0;
        end
        else
        begin
            s_axi_awready <= wr_fire;
            s_axi_wready <= wr_fire;
            s_axi_arready <= rd_fire;
            fifo_in_valid <= 1'b0;
            fifo_out_take <= 1'b0;
            disk_wr_strobe <= 1'b0;
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (widx >= `IDX_CMD && widx <= `IDX_ERROR) ? `RESP_OKAY : `RESP_DECERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
            // host writes; sequencer updates below win on the same cycle
            if (we && widx == `IDX_OPCTL)
            begin
                opctl <= wd[4:0];
                if (wd[`OC_REENABLE] && !wd[`OC_RESET] && !opctl[`OC_RESET])
                    disabled <= 1'b0;
            end
            if (we && widx == `IDX_OPCOUNT)
                opcount <= wd;
            if (we && widx == `IDX_SECTCNT)
                sect_cnt <= wd;
            if (we && widx == `IDX_PATTERN)
                pattern <= wd;
            if (we && widx == `IDX_HDRCTL)
                subst <= wd[`HDRCTL_SUBST];
            if (we && widx == `IDX_HBC)
            begin
                hbc <= wd;
                hbc_written <= 1'b1;
                next_cmd_ready <= 1'b0;
            end
            if (we && widx == `IDX_CMD && state != S_ERR && !disabled)
            begin
                cmd <= wd;
                if (state == S_IDLE)
                begin
                    if (wd[`CMD_DO_HI:`CMD_DO_LO] != `OP_NONE || wd[`CMD_HO_HI:`CMD_HO_LO] != `OP_NONE)
                        state <= S_WAIT_START;
                end
                else
                    cmd_pending <= 1'b1;
            end
            case (state)
                S_WAIT_START:
                begin
                    index_seen <= 2'h0;
                    if (cmd[`CMD_START_SEL] ? (!hard_sectored || sector_pulse) : index_pulse)
                        state <= S_SEARCH;
                end
                S_SEARCH:
                begin
                    if (index_pulse)
                        index_seen <= index_seen + 2'h1;
                    if (index_pulse && index_seen == `INDEX_LIMIT - 2'h1)
                    begin
                        err[`ERR_NOT_FOUND] <= 1'b1;
                        state <= S_ERR;
                    end
                    else if (id_found && opctl[`OC_INTERLOCK] && il_armed && !hbc_written)
                    begin
                        err[`ERR_LATE_IL] <= 1'b1;
                        state <= S_ERR;
                    end
                    else if (id_found && byte_match && (hop == `OP_NONE || id_check_ok))
                    begin
                        next_cmd_ready <= 1'b1;
                        il_armed <= 1'b1;
                        hbc_written <= 1'b0;
                        if (dop == `DO_WRITE)
                        begin
                            disk_wr_gate <= 1'b1;
                            state <= S_WPRE;
                        end
                        else if (dop == `OP_NONE)
                            state <= S_SECT_END;
                        else
                            state <= S_DSYNC;
                    end
                    else if (id_found && hop == `HO_COMPARE && byte_match)
                    begin
                        err[`ERR_HDR_FAIL] <= 1'b1;
                        state <= S_ERR;
                    end
                end
                S_DSYNC:
                begin
                    if (data_sync_found)
                        state <= S_RDATA;
                    else if (data_sync_missing)
                    begin
                        err[`ERR_NO_SYNC] <= 1'b1;
                        state <= S_ERR;
                    end
                end
                S_RDATA:
                begin
                    if (disk_byte_valid && dop == `DO_READ && !fifo_in_ready)
                    begin
                        err[`ERR_FIFO_LOST] <= 1'b1;
                        state <= S_ERR;
                    end
                    else if (disk_byte_valid)
                    begin
                        fifo_in_valid <= dop == `DO_READ;
                        fifo_in_data <= disk_byte;
                        if (last_byte)
                            state <= S_RCHK;
                    end
                end
                S_RCHK:
                begin
                    if (disk_byte_valid && disk_byte != crc)
                    begin
                        err[`ERR_DATA_FIELD] <= 1'b1;
                        state <= S_ERR;
                    end
                    else if (disk_byte_valid)
                        state <= S_SECT_END;
                end
                S_WPRE:
                begin
                    if (disk_byte_tick)
                    begin
                        disk_wr_strobe <= 1'b1;
                        disk_wr_byte <= count == 10'h000 ? `SYNC_BYTE : `PREAMBLE_BYTE;
                        if (count == 10'h000)
                            state <= S_WDATA;
                    end
                end
                S_WDATA:
                begin
                    if (disk_byte_tick && !fifo_out_valid)
                    begin
                        err[`ERR_FIFO_LOST] <= 1'b1;
                        state <= S_ERR;
                    end
                    else if (disk_byte_tick)
                    begin
                        disk_wr_strobe <= 1'b1;
                        disk_wr_byte <= fifo_out_data;
                        fifo_out_take <= 1'b1;
                        if (last_byte)
                            state <= S_WCHK;
                    end
                end
                S_WCHK:
                begin
                    if (disk_byte_tick)
                    begin
                        disk_wr_strobe <= 1'b1;
                        disk_wr_byte <= crc;
                        state <= S_SECT_END;
                    end
                end
                S_SECT_END:
                begin
                    sect_cnt <= sect_cnt + 8'h01;
                    disk_wr_gate <= 1'b0; // gate falls one clock edge after the edge that raises the check byte strobe
                    index_seen <= 2'h0;
                    if (cmd[`CMD_MULTI])
                        opcount <= opcount - 8'h01;
                    if (cmd[`CMD_MULTI] && opcount > 8'h01)
                        state <= S_SEARCH;
                    else if (cmd_pending)
                    begin
                        cmd_pending <= 1'b0;
                        state <= S_WAIT_START;
                    end
                    else
                    begin
                        il_armed <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                default:
                begin
                    il_armed <= il_armed;
                end
            endcase
            if (active && sector_overrun)
            begin
                err[`ERR_OVERRUN] <= 1'b1;
                state <= S_ERR;
            end
            if (correction_failed)
            begin
                err[`ERR_CORR_FAIL] <= 1'b1;
                state <= S_ERR;
            end
            if (state == S_ERR)
                disk_wr_gate <= 1'b0;
            // held reset bit forces the default state; flags stay until here
            if (opctl[`OC_RESET])
            begin
                state <= S_IDLE;
                err <= 8'h00;
                disabled <= 1'b1;
                next_cmd_ready <= 1'b0;
                hbc_written <= 1'b0;
                il_armed <= 1'b0;
                cmd_pending <= 1'b0;
                disk_wr_gate <= 1'b0;
            end
            irq <= (opctl[`OC_HDR_IE] && next_cmd_ready) || (opctl[`OC_ERR_IE] && err != 8'h00);
        end
    end
endmodule // disk_command_sequencer

// ===== bench/disk_seq_sva.sv
// concurrent checks on the disk command sequencer ports
module disk_seq_sva
(
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_wvalid,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire disk_byte_valid,
    input wire fifo_in_valid,
    input wire disk_wr_gate,
    input wire disk_wr_strobe,
    input wire irq
);
default clocking @(posedge aclk);
endclocking
default disable iff (!aresetn);
// ****************
// write and read handshakes
// ****************
sequence wr_req;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
endsequence
sequence wr_ans;
    s_axi_awready && s_axi_wready && s_axi_bvalid;
endsequence
wr_answer_a: assert property (wr_req |=> wr_ans)
    else $error("write not answered");
wr_pulse_a: assert property (s_axi_awready |=> !s_axi_awready && !s_axi_wready)
    else $error("write ready too long");
b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
rd_answer_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered");
r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
// ****************
// disk side
// ****************
fifo_lag_a: assert property (fifo_in_valid |-> $past(disk_byte_valid))
    else $error("fifo push without disk byte");
gate_strobe_a: assert property (disk_wr_strobe |-> disk_wr_gate)
    else $error("write strobe outside gate");
reset_quiet_a: assert property ($rose(aresetn) |-> !irq && !disk_wr_gate && !fifo_in_valid)
    else $error("outputs active after reset");
endmodule // disk_seq_sva

bind disk_command_sequencer disk_seq_sva disk_seq_sva_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .disk_byte_valid, .fifo_in_valid, .disk_wr_gate, .disk_wr_strobe, .irq);

// ===== bench/disk_drive_model.sv
// drive model: index, sector, header and data field timing
module disk_drive_model #(parameter int SL = 1200, parameter int NS = 4)
(
    input wire aclk,
    input wire aresetn,
    output logic index_pulse,
    output logic sector_pulse,
    output logic id_found,
    output logic [7:0] id_byte,
    output logic id_check_ok,
    output logic data_sync_found,
    output logic data_sync_missing,
    output logic disk_byte_valid,
    output logic [7:0] disk_byte,
    output logic disk_byte_tick,
    output logic sector_overrun,
    output logic correction_failed
);
timeunit 1ns;
timeprecision 100ps;
int t, s, k;
logic [7:0] crc, nc;
assign k = (t - 10) / 2;
assign sector_pulse = aresetn && t == 0;
assign index_pulse = sector_pulse && s == 0;
assign id_found = t == 4;
// an undriven bus shows a moving pattern, never the last value
assign id_byte = id_found ? s[7:0] : ~t[7:0];
assign id_check_ok = id_found;
assign data_sync_found = t == 8;
assign data_sync_missing = 1'b0;
assign disk_byte_valid = t >= 10 && t < 1036 && !t[0];
assign disk_byte = !disk_byte_valid ? ~t[7:0] : k < 512 ? k[7:0] ^ s[7:0] : crc;
assign disk_byte_tick = t[0];
assign sector_overrun = 1'b0;
assign correction_failed = 1'b0;
always_comb
begin
    nc = crc ^ disk_byte;
    for (int i = 0; i < 8; i++)
        nc = nc[7] ? {nc[6:0], 1'b0} ^ 8'h07 : {nc[6:0], 1'b0};
end
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        t <= 0;
        s <= 0;
    end
    else
    begin
        t <= t == SL - 1 ? 0 : t + 1;
        if (t == SL - 1)
            s <= s == NS - 1 ? 0 : s + 1;
    end
    if (t == 8)
        crc <= 8'h00;
    else if (disk_byte_valid && k < 512)
        crc <= nc;
end
endmodule // disk_drive_model

// ===== bench/testbench.sv
// self-checking testbench for the disk command sequencer
`include "disk_seq_regs.vh"
module testbench;
timeunit 1ns;
timeprecision 100ps;
logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hard_sectored, index_pulse, sector_pulse;
logic id_found, id_check_ok, data_sync_found, data_sync_missing, disk_byte_valid, disk_byte_tick;
logic sector_overrun, correction_failed, fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_take;
logic disk_wr_gate, disk_wr_strobe, irq;
logic [7:0] s_axi_awaddr, s_axi_araddr, id_byte, disk_byte, fifo_in_data, fifo_out_data, disk_wr_byte;
logic [7:0] sync_b, last_id, wr_id, fd;
logic [31:0] s_axi_wdata, s_axi_rdata, d;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp, rr;
int fail_count, total_checks, n_rd, n_wr;
disk_command_sequencer disk_command_sequencer_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .hard_sectored, .index_pulse, .sector_pulse, .id_found, .id_byte, .id_check_ok, .data_sync_found,
    .data_sync_missing, .disk_byte_valid, .disk_byte, .disk_byte_tick, .sector_overrun, .correction_failed,
    .fifo_in_valid, .fifo_in_data, .fifo_in_ready, .fifo_out_valid, .fifo_out_data, .fifo_out_take,
    .disk_wr_gate, .disk_wr_strobe, .disk_wr_byte, .irq);
disk_drive_model disk_drive_model_i (.aclk, .aresetn, .index_pulse, .sector_pulse, .id_found, .id_byte,
    .id_check_ok, .data_sync_found, .data_sync_missing, .disk_byte_valid, .disk_byte, .disk_byte_tick,
    .sector_overrun, .correction_failed);
// ****************
// bus tasks and monitors
// ****************
initial
begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
end
always @(posedge aclk)
begin
    if (fifo_out_take)
        fifo_out_data <= fifo_out_data + 8'h01;
    if (fifo_in_valid)
        n_rd <= n_rd + 1;
    if (disk_wr_strobe)
        n_wr <= n_wr + 1;
    if (id_found)
        last_id <= id_byte;
    if (fifo_in_valid && n_rd == 0)
        fd <= fifo_in_data;
    if (disk_wr_strobe && n_wr == 12)
    begin
        sync_b <= disk_wr_byte;
        wr_id <= last_id;
    end
end
task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
        fail_count++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
endtask
task wr(input [5:0] i, input [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
endtask
task rd(input [5:0] i, output [31:0] v);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
endtask
// only status is polled while a command runs
task wait_idle;
    d = 32'h1;
    while (d[`ST_BUSY] && !d[`ST_ERROR])
    begin
        repeat (50) @(posedge aclk);
        rd(`IDX_STATUS, d);
    end
endtask
task wait_ready;
    d = 32'h0;
    while (!d[`ST_NEXT_CMD])
        rd(`IDX_STATUS, d);
endtask
task close_out;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
initial
begin
    #(25 * 60000);
    fail_count++;
    close_out;
end
// ****************
// scenarios
// ****************
initial
begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hard_sectored} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fifo_out_data, n_rd, n_wr} = 0;
    {s_axi_wstrb, fifo_in_ready, fifo_out_valid} = 6'h07;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`IDX_OPCOUNT, d);
    chk(d, {24'h0, `OPCOUNT_RST});
    rd(6'h3f, d);
    chk(rr, `RESP_DECERR);
    wr(`IDX_CMD, 8'hc2);
    wait_idle;
    chk(n_rd, 512);
    wr(`IDX_HDRCTL, 8'h01);
    wr(`IDX_SECTCNT, 8'h01);
    wr(`IDX_OPCOUNT, 8'h02);
    n_rd = 0;
    wr(`IDX_CMD, 8'hd6);
    wait_idle;
    chk(n_rd, 1024);
    chk(fd, 8'h01);
    rd(`IDX_SECTCNT, d);
    chk(d, 32'h3);
    wr(`IDX_OPCOUNT, 8'h01);
    wr(`IDX_CMD, 8'h80);
    wait_idle;
    chk(n_wr, `PREAMBLE_BYTES + `DATA_BYTES + 2);
    chk(sync_b, `SYNC_BYTE);
    chk(wr_id, 8'h00);
    wr(`IDX_HDRCTL, 8'h00);
    wr(`IDX_OPCTL, 8'h10);
    wr(`IDX_PATTERN, 8'h77);
    wr(`IDX_CMD, 8'h52);
    wait_idle;
    rd(`IDX_ERROR, d);
    chk(d, 32'h04);
    chk(irq, 1'b1);
    n_rd = 0;
    wr(`IDX_CMD, 8'hc2);
    wr(`IDX_OPCTL, 8'h11);
    wr(`IDX_OPCTL, 8'h10);
    wr(`IDX_CMD, 8'hc2);
    rd(`IDX_STATUS, d);
    chk(d[`ST_DISABLED], 1'b1);
    wr(`IDX_OPCTL, 8'h12);
    rd(`IDX_STATUS, d);
    chk(d[3:0], 4'h0);
    chk(irq, 1'b0);
    repeat (2400) @(posedge aclk);
    chk(n_rd, 0);
    wr(`IDX_OPCTL, 8'h06);
    wr(`IDX_CMD, 8'hc2);
    wait_ready;
    wr(`IDX_CMD, 8'hc2);
    wr(`IDX_HBC, 8'h00);
    wait_idle;
    chk(n_rd, 1024);
    wr(`IDX_HBC, 8'h00);
    wr(`IDX_OPCOUNT, 8'h03);
    wr(`IDX_CMD, 8'hc6);
    wait_ready;
    wr(`IDX_HBC, 8'h00);
    rd(`IDX_STATUS, d);
    chk(d[`ST_NEXT_CMD], 1'b0);
    wait_ready;
    wait_idle;
    rd(`IDX_ERROR, d);
    chk(d, 32'h20);
    close_out;
end
endmodule // testbench
